// File: rtl/multilevel_interrupt_standby_wake.sv
// interrupt arbitration, nesting and standby release logic
`include "intc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module multilevel_interrupt_standby_wake #(
  parameter int NUM_SRC = `NUM_SRC,
  parameter int NUM_VEC = `NUM_VEC
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire intc_pkg::ext_pins_s   i_pins,
  input  wire intc_pkg::periph_evt_s i_evt,
  input  wire logic                 i_xtal_on,
  input  wire logic [3:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [7:0]           o_rdata,
  output var intc_pkg::core_req_s    o_core,
  input  wire logic                 i_ack,
  input  wire logic                 i_ret,
  output var intc_pkg::power_ctl_s   o_power
);

  function automatic logic [23:0] vec_mask(input logic [3:0] v);
    unique case (v)
      4'h0: vec_mask = `VMASK0;
      4'h1: vec_mask = `VMASK1;
      4'h2: vec_mask = `VMASK2;
      4'h3: vec_mask = `VMASK3;
      4'h4: vec_mask = `VMASK4;
      4'h5: vec_mask = `VMASK5;
      4'h6: vec_mask = `VMASK6;
      4'h7: vec_mask = `VMASK7;
      4'h8: vec_mask = `VMASK8;
      4'h9: vec_mask = `VMASK9;
      default: vec_mask = 24'h00_0000;
    endcase
  endfunction : vec_mask

  function automatic intc_pkg::lvl_t vec_lvl(input logic [3:0] v, input logic up);
    if (!up) begin
      vec_lvl = `LVL_LOW;
    end else if (v < `NUM_TOP_VEC) begin
      vec_lvl = `LVL_TOP;
    end else begin
      vec_lvl = `LVL_HIGH;
    end
  endfunction : vec_lvl

  function automatic intc_pkg::lvl_t top_lvl(input logic [2:0] m);
    if (m[2]) begin
      top_lvl = `LVL_TOP;
    end else if (m[1]) begin
      top_lvl = `LVL_HIGH;
    end else if (m[0]) begin
      top_lvl = `LVL_LOW;
    end else begin
      top_lvl = `LVL_NONE;
    end
  endfunction : top_lvl

  logic [6:0]          s1_r, s2_r, s3_r;
  logic [6:0]          filt_r, filt_d_r;
  logic [6:0]          rise;
  logic [23:0]         flags_r, en_r, list_r;
  logic [23:0]         set_v, clr_v, pend;
  logic [9:0]          lvl_sel_r;
  logic [1:0]          ext_lvl_r;
  logic [2:0]          insvc_r;
  logic [7:0]          rdata_r;
  logic [9:0]          vp;
  logic                found;
  logic [3:0]          best_v;
  intc_pkg::lvl_t      best_lvl, cur_lvl;
  intc_pkg::core_req_s core_r;
  intc_pkg::power_ctl_s pwr_r;
  intc_pkg::standby_e  st_r, st_nxt;
  logic [1:0]          st_code;
  logic                keep_off_r;
  logic [23:0]         hold_ok, xhold_ok;

  // three-stage pin synchroniser
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_r <= 7'h00;
      s2_r <= 7'h00;
      s3_r <= 7'h00;
    end else begin
      s1_r <= i_pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      filt_r   <= 7'h00;
      filt_d_r <= 7'h00;
    end else begin
      filt_r   <= (filt_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
      filt_d_r <= filt_r;
    end
  end

  assign rise = filt_r & ~filt_d_r;

  always_comb begin
    set_v     = 24'h00_0000;
    set_v[0]  = ext_lvl_r[0] ? filt_r[6] : rise[6];
    set_v[1]  = ext_lvl_r[1] ? filt_r[5] : rise[5];
    set_v[2]  = rise[4];
    set_v[3]  = i_evt.timer_zero_low_event;
    set_v[4]  = rise[2];
    set_v[5]  = i_evt.remote_receiver_event;
    set_v[6]  = rise[3];
    set_v[7]  = rise[1];
    set_v[8]  = i_evt.base_timer_event_a;
    set_v[9]  = i_evt.base_timer_event_b;
    set_v[10] = i_evt.timer_zero_high_event;
    set_v[11] = i_evt.timer_one_low_event;
    set_v[12] = i_evt.timer_one_high_event;
    set_v[13] = i_evt.sync_serial_port_zero;
    set_v[14] = i_evt.async_serial_port_rx;
    set_v[15] = i_evt.serial_port_one;
    set_v[16] = i_evt.async_serial_port_tx;
    set_v[17] = i_evt.adc_done;
    set_v[18] = i_evt.timer_six_event;
    set_v[19] = i_evt.timer_seven_event;
    set_v[20] = rise[0];
    set_v[21] = i_evt.timer_four_event;
    set_v[22] = i_evt.timer_five_event;
    set_v[23] = i_evt.pulse_width_channel_a | i_evt.pulse_width_channel_b;
  end

  // write-one-to-clear of the flag bytes
  always_comb begin
    clr_v = 24'h00_0000;
    if (i_wr) begin
      unique case (i_addr)
        `REG_FLAG0: clr_v[7:0]   = i_wdata;
        `REG_FLAG1: clr_v[15:8]  = i_wdata;
        `REG_FLAG2: clr_v[23:16] = i_wdata;
        default:    clr_v = 24'h00_0000;
      endcase
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_r <= 24'h00_0000;
    end else begin
      flags_r <= (flags_r & ~clr_v) | set_v;
    end
  end

  // software configuration
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_r      <= 24'h00_0000;
      lvl_sel_r <= 10'h000;
      ext_lvl_r <= 2'h0;
    end else if (i_wr) begin
      unique case (i_addr)
        `REG_EN0:    en_r[7:0]       <= i_wdata;
        `REG_EN1:    en_r[15:8]      <= i_wdata;
        `REG_EN2:    en_r[23:16]     <= i_wdata;
        `REG_LVL0:   lvl_sel_r[7:0]  <= i_wdata;
        `REG_LVL1:   lvl_sel_r[9:8]  <= i_wdata[1:0];
        `REG_EXTCFG: ext_lvl_r       <= i_wdata[1:0];
        default:     ;
      endcase
    end
  end

  assign pend    = flags_r & en_r;
  assign cur_lvl = top_lvl(insvc_r);

  // highest level wins, above current only
  always_comb begin
    found    = 1'b0;
    best_v   = 4'h0;
    best_lvl = cur_lvl;
    for (int v = 0; v < NUM_VEC; v++) begin
      vp[v] = |(pend & vec_mask(4'(v)));
      // strict compare keeps the lowest vector
      if (vp[v] && vec_lvl(4'(v), lvl_sel_r[v]) > best_lvl) begin
        found    = 1'b1;
        best_v   = 4'(v);
        best_lvl = vec_lvl(4'(v), lvl_sel_r[v]);
      end
    end
  end

  // request to the core, paused the cycle after an acknowledge
  // vector fields keep the last winner so status shows the taken vector
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_r <= '0;
    end else begin
      core_r.req <= found & ~(i_ack & core_r.req) & ~i_ret;
      if (found) begin
        core_r.level    <= best_lvl;
        core_r.vec_idx  <= best_v;
        core_r.vec_addr <= `VEC_BASE + (20'(best_v) << `VEC_SHIFT);
      end
    end
  end

  assign o_core = core_r;

  // in-service level stack, raise and restore
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      insvc_r <= 3'h0;
    end else begin
      if (i_ack && core_r.req) begin
        insvc_r <= (i_ret ? (insvc_r & ~(3'(cur_lvl == `LVL_TOP) << 2)
                                     & ~(3'(cur_lvl == `LVL_HIGH) << 1)
                                     & ~3'(cur_lvl == `LVL_LOW)) : insvc_r)
                   | (3'h1 << (core_r.level - `LVL_LOW));
      end else if (i_ret) begin
        insvc_r <= insvc_r & ~(3'(cur_lvl == `LVL_TOP) << 2)
                           & ~(3'(cur_lvl == `LVL_HIGH) << 1)
                           & ~3'(cur_lvl == `LVL_LOW);
      end
    end
  end

  // source list of the taken vector
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      list_r <= 24'h00_0000;
    end else if (i_ack && core_r.req) begin
      list_r <= pend & vec_mask(core_r.vec_idx);
    end
  end

  // hold wake set, ext zero/one in level mode only
  assign hold_ok  = pend & `HOLD_WAKE & {22'h3F_FFFF, ext_lvl_r};
  // crystal hold adds base timer and remote
  assign xhold_ok = pend & `XHOLD_WAKE & {22'h3F_FFFF, ext_lvl_r};

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      intc_pkg::ST_RUN: begin
        if (i_wr && i_addr == `REG_STBY) begin
          unique case (i_wdata[1:0])
            `STBY_HALT:  st_nxt = intc_pkg::ST_HALT;
            `STBY_HOLD:  st_nxt = intc_pkg::ST_HOLD;
            `STBY_XHOLD: st_nxt = intc_pkg::ST_XHOLD;
            `STBY_RUN:   st_nxt = intc_pkg::ST_RUN;
          endcase
        end
      end
      intc_pkg::ST_HALT: begin
        if (|pend) begin
          st_nxt = intc_pkg::ST_RUN;
        end
      end
      intc_pkg::ST_HOLD: begin
        if (|hold_ok) begin
          st_nxt = intc_pkg::ST_RUN;
        end
      end
      intc_pkg::ST_XHOLD: begin
        if (|xhold_ok) begin
          st_nxt = intc_pkg::ST_RUN;
        end
      end
    endcase
  end

  // standby state; reset also releases every mode
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= intc_pkg::ST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      keep_off_r <= 1'b0;
    end else if (st_r == intc_pkg::ST_RUN && st_nxt == intc_pkg::ST_XHOLD) begin
      keep_off_r <= ~i_xtal_on;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pwr_r <= '0;
    end else begin
      pwr_r.cpu_stop        <= st_r != intc_pkg::ST_RUN;
      pwr_r.periph_stop     <= st_r == intc_pkg::ST_HOLD || st_r == intc_pkg::ST_XHOLD;
      pwr_r.base_timer_stop <= st_r == intc_pkg::ST_HOLD;
      pwr_r.main_osc_stop   <= st_r == intc_pkg::ST_HOLD || st_r == intc_pkg::ST_XHOLD;
      pwr_r.xtal_stop       <= st_r == intc_pkg::ST_HOLD ||
                               (st_r == intc_pkg::ST_XHOLD && keep_off_r);
    end
  end

  assign o_power = pwr_r;

  always_comb begin
    unique case (st_r)
      intc_pkg::ST_RUN:   st_code = `STBY_RUN;
      intc_pkg::ST_HALT:  st_code = `STBY_HALT;
      intc_pkg::ST_HOLD:  st_code = `STBY_HOLD;
      intc_pkg::ST_XHOLD: st_code = `STBY_XHOLD;
    endcase
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `REG_FLAG0:  rdata_r <= flags_r[7:0];
        `REG_FLAG1:  rdata_r <= flags_r[15:8];
        `REG_FLAG2:  rdata_r <= flags_r[23:16];
        `REG_EN0:    rdata_r <= en_r[7:0];
        `REG_EN1:    rdata_r <= en_r[15:8];
        `REG_EN2:    rdata_r <= en_r[23:16];
        `REG_LVL0:   rdata_r <= lvl_sel_r[7:0];
        `REG_LVL1:   rdata_r <= {6'h00, lvl_sel_r[9:8]};
        `REG_EXTCFG: rdata_r <= {6'h00, ext_lvl_r};
        `REG_STBY:   rdata_r <= {6'h00, st_code};
        `REG_STAT:   rdata_r <= {core_r.vec_idx, 1'b0, insvc_r};
        `REG_LIST0:  rdata_r <= list_r[7:0];
        `REG_LIST1:  rdata_r <= list_r[15:8];
        `REG_LIST2:  rdata_r <= list_r[23:16];
        default:     rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign o_rdata = rdata_r;

  // checking helper: any pending vector that should beat the winner
  logic beat;
  always_comb begin
    beat = 1'b0;
    for (int v = 0; v < NUM_VEC; v++) begin
      if (vp[v] && 4'(v) != best_v) begin
        if (vec_lvl(4'(v), lvl_sel_r[v]) > best_lvl) begin
          beat = 1'b1;
        end
        if (vec_lvl(4'(v), lvl_sel_r[v]) == best_lvl && 4'(v) < best_v) begin
          beat = 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_refuse_low_level: assert property (
    o_core.req |-> o_core.level > cur_lvl)
    else $error("request not above level in service");

  a_arbiter_winner: assert property (
    found |-> !beat)
    else $error("arbiter chose a beaten vector");

  a_top_level_vec: assert property (
    o_core.req && o_core.level == `LVL_TOP |-> o_core.vec_idx < `NUM_TOP_VEC)
    else $error("highest level on a wrong vector");

  a_grant_raise_level: assert property (
    i_ack && o_core.req && !i_ret |=> cur_lvl == $past(o_core.level) && !o_core.req)
    else $error("grant did not raise level");

  a_ret_restore_level: assert property (
    i_ret && !i_ack && insvc_r != 3'h0 |=> cur_lvl < $past(cur_lvl))
    else $error("return did not lower level");

  a_halt_keeps_osc: assert property (
    st_r == intc_pkg::ST_HALT |=> o_power.cpu_stop && !o_power.periph_stop
                                  && !o_power.main_osc_stop && !o_power.xtal_stop)
    else $error("halt controls wrong");

  a_halt_any_wake: assert property (
    st_r == intc_pkg::ST_HALT && |pend |=> st_r == intc_pkg::ST_RUN ##1 !o_power.cpu_stop)
    else $error("halt not released by request");

  a_hold_all_stop: assert property (
    st_r == intc_pkg::ST_HOLD |=> o_power.periph_stop && o_power.main_osc_stop
                                  && o_power.xtal_stop && o_power.base_timer_stop)
    else $error("hold controls wrong");

  a_hold_wake_src: assert property (
    st_r == intc_pkg::ST_HOLD && |hold_ok |=> st_r == intc_pkg::ST_RUN)
    else $error("hold not released");

  a_edge_no_wake: assert property (
    st_r == intc_pkg::ST_HOLD && pend == `VMASK0 && !ext_lvl_r[0]
    |=> st_r == intc_pkg::ST_HOLD)
    else $error("edge request released hold");

  a_xhold_keep_xtal: assert property (
    st_r == intc_pkg::ST_XHOLD && $past(st_r) == intc_pkg::ST_XHOLD
    |=> $stable(o_power.xtal_stop) && !o_power.base_timer_stop)
    else $error("crystal hold changed crystal state");

  a_flag_set_wins: assert property (
    |(set_v & clr_v) |=> |(flags_r & $past(set_v & clr_v)))
    else $error("clear beat a set");

endmodule : multilevel_interrupt_standby_wake

`default_nettype wire

// File: rtl/intc_consts.svh
// register map, level codes and vector tables of the interrupt and standby block
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

`define NUM_SRC      24
`define NUM_VEC      10
`define NUM_TOP_VEC  4'h2

`define REG_FLAG0    4'h0
`define REG_FLAG1    4'h1
`define REG_FLAG2    4'h2
`define REG_EN0      4'h3
`define REG_EN1      4'h4
`define REG_EN2      4'h5
`define REG_LVL0     4'h6
`define REG_LVL1     4'h7
`define REG_EXTCFG   4'h8
`define REG_STBY     4'h9
`define REG_STAT     4'hA
`define REG_LIST0    4'hB
`define REG_LIST1    4'hC
`define REG_LIST2    4'hD

`define LVL_NONE     2'h0
`define LVL_LOW      2'h1
`define LVL_HIGH     2'h2
`define LVL_TOP      2'h3

`define STBY_RUN     2'h0
`define STBY_HALT    2'h1
`define STBY_HOLD    2'h2
`define STBY_XHOLD   2'h3

`define VEC_BASE     20'h0_0003
`define VEC_SHIFT    3

`define VMASK0       24'h00_0001
`define VMASK1       24'h00_0002
`define VMASK2       24'h00_003C
`define VMASK3       24'h00_03C0
`define VMASK4       24'h00_0400
`define VMASK5       24'h00_1800
`define VMASK6       24'h00_6000
`define VMASK7       24'h01_8000
`define VMASK8       24'h0E_0000
`define VMASK9       24'hF0_0000

`define HOLD_WAKE    24'h10_0097
`define XHOLD_WAKE   24'h10_03B7

`endif

// File: rtl/intc_pkg.sv
// types shared by the interrupt and standby block
package intc_pkg;
  typedef logic [1:0] lvl_t;

  typedef struct packed {
    logic ext_irq_zero;
    logic ext_irq_one;
    logic ext_irq_two;
    logic ext_irq_three;
    logic ext_irq_group_four;
    logic ext_irq_group_five;
    logic port_zero_irq;
  } ext_pins_s;

  typedef struct packed {
    logic timer_zero_low_event;
    logic timer_zero_high_event;
    logic timer_one_low_event;
    logic timer_one_high_event;
    logic base_timer_event_a;
    logic base_timer_event_b;
    logic remote_receiver_event;
    logic sync_serial_port_zero;
    logic async_serial_port_rx;
    logic serial_port_one;
    logic async_serial_port_tx;
    logic adc_done;
    logic timer_six_event;
    logic timer_seven_event;
    logic timer_four_event;
    logic timer_five_event;
    logic pulse_width_channel_a;
    logic pulse_width_channel_b;
  } periph_evt_s;

  typedef struct packed {
    logic        req;
    lvl_t        level;
    logic [3:0]  vec_idx;
    logic [19:0] vec_addr;
  } core_req_s;

  typedef struct packed {
    logic cpu_stop;
    logic periph_stop;
    logic base_timer_stop;
    logic main_osc_stop;
    logic xtal_stop;
  } power_ctl_s;

  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_HOLD, ST_XHOLD} standby_e;
endpackage : intc_pkg

// File: sim/core_model.sv
// processor core model that takes vectors and returns from handlers
`timescale 1ns/1ns
`default_nettype none

module core_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire intc_pkg::core_req_s   i_core,
  input  wire logic                 i_ack_en,
  input  wire logic [3:0]           i_delay,
  input  wire logic                 i_ret_cmd,
  output logic                      o_ack,
  output logic                      o_ret
);
  logic [3:0] wait_r;

  // take the shown vector after a chosen number of cycles
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ack  <= 1'b0;
      wait_r <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      if (i_core.req && i_ack_en && !o_ack) begin
        if (wait_r >= i_delay) begin
          o_ack  <= 1'b1;
          wait_r <= 4'h0;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end else begin
        wait_r <= 4'h0;
      end
    end
  end

  // handler return is a one-cycle pulse
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ret <= 1'b0;
    end else begin
      o_ret <= i_ret_cmd;
    end
  end
endmodule : core_model

`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench of the interrupt and standby block
`timescale 1ns/1ns
`default_nettype none
`include "intc_consts.svh"

`define CHK(act, exp, msg) begin \
  comparisons++; \
  if ((act) !== (exp)) begin \
    mismatches++; \
    $display("unexpected %0t %s got %h exp %h", $time, msg, act, exp); \
  end \
end

module tb_top;
  logic                  clk;
  logic                  reset_n;
  logic                  xtal_on;
  logic                  wr;
  logic                  rd;
  logic                  ack;
  logic                  ret;
  logic                  ack_en;
  logic                  ret_cmd;
  logic [3:0]            addr;
  logic [3:0]            delay;
  logic [7:0]            wdata;
  logic [7:0]            rdata;
  logic [7:0]            v;
  logic [23:0]           list;
  intc_pkg::ext_pins_s   pins;
  intc_pkg::periph_evt_s evt;
  intc_pkg::core_req_s   core_req;
  intc_pkg::power_ctl_s  power;
  int                    mismatches;
  int                    comparisons;
  logic [3:0] vec_tab [18] = '{2, 4, 5, 5, 3, 3, 2, 6, 6, 7, 7, 8, 8, 8, 9, 9, 9, 9};
  logic [4:0] src_tab [18] = '{3, 10, 11, 12, 8, 9, 5, 13, 14, 15, 16, 17, 18, 19, 21, 22, 23, 23};

  multilevel_interrupt_standby_wake dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_pins(pins), .i_evt(evt), .i_xtal_on(xtal_on),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_core(core_req), .i_ack(ack), .i_ret(ret), .o_power(power)
  );

  core_model core_side (
    .i_clk(clk), .i_reset_n(reset_n), .i_core(core_req), .i_ack_en(ack_en),
    .i_delay(delay), .i_ret_cmd(ret_cmd), .o_ack(ack), .o_ret(ret)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  task automatic clr_flags();
    wr_reg(`REG_FLAG0, 8'hFF);
    wr_reg(`REG_FLAG1, 8'hFF);
    wr_reg(`REG_FLAG2, 8'hFF);
  endtask : clr_flags

  task automatic pulse_evt(input logic [17:0] m);
    @(posedge clk);
    evt <= intc_pkg::periph_evt_s'(m);
    @(posedge clk);
    evt <= '0;
  endtask : pulse_evt

  task automatic pulse_pin(input logic [6:0] m);
    @(posedge clk);
    pins <= intc_pkg::ext_pins_s'(m);
    tick(6);
    pins <= '0;
    tick(4);
  endtask : pulse_pin

  task automatic do_ret();
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    tick(3);
  endtask : do_ret

  task automatic wait_req();
    int n;
    n = 0;
    while (core_req.req !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (core_req.req !== 1'b1) begin
      mismatches++;
      $display("unexpected %0t request never shown", $time);
      print_verdict();
    end
  endtask : wait_req

  task automatic wait_wake(input logic [4:0] busy);
    int n;
    n = 0;
    while (power !== 5'h00 && n < 12) begin
      @(posedge clk);
      n++;
    end
    if (power !== 5'h00) begin
      mismatches++;
      $display("unexpected %0t standby never released", $time);
      print_verdict();
    end
    `CHK(power, 5'h00, "no wake")
    rd_reg(`REG_STBY, v);
    `CHK(v, {3'h0, busy}, "run code after wake")
  endtask : wait_wake

  task automatic test_reset();
    rd_reg(`REG_STAT, v);
    `CHK(v, 8'h00, "status after reset")
    rd_reg(4'hF, v);
    `CHK(v, 8'h00, "unmapped read")
    `CHK(power, 5'h00, "power after reset")
    wr_reg(`REG_EN0, 8'hFF);
    wr_reg(`REG_EN1, 8'hFF);
    wr_reg(`REG_EN2, 8'hFF);
    $display("test reset done");
  endtask : test_reset

  task automatic test_map();
    for (int i = 0; i < 18; i++) begin
      delay <= 4'(i % 3);
      pulse_evt(18'h1 << (17 - i));
      wait_req();
      `CHK(core_req.vec_idx, vec_tab[i], "vector index")
      `CHK(core_req.vec_addr, 20'h0_0003 + 20'(vec_tab[i]) * 20'h0_0008, "address")
      `CHK(core_req.level, `LVL_LOW, "level")
      tick(6);
      rd_reg(`REG_STAT, v);
      `CHK(v, {vec_tab[i], 4'h1}, "status in service")
      rd_reg(`REG_LIST0, list[7:0]);
      rd_reg(`REG_LIST1, list[15:8]);
      rd_reg(`REG_LIST2, list[23:16]);
      `CHK(list, 24'h1 << src_tab[i], "source list")
      clr_flags();
      do_ret();
      rd_reg(`REG_STAT, v);
      `CHK(v[2:0], 3'h0, "level restored")
    end
    $display("test map done");
  endtask : test_map

  task automatic test_prio();
    ack_en <= 1'b0;
    pulse_evt(18'h1_0400);
    wait_req();
    `CHK(core_req.vec_idx, 4'h4, "tie to lowest vector")
    clr_flags();
    wr_reg(`REG_LVL0, 8'h40);
    pulse_evt(18'h1_0400);
    wait_req();
    `CHK(core_req.vec_idx, 4'h6, "higher level wins")
    `CHK(core_req.level, `LVL_HIGH, "high level")
    clr_flags();
    tick(3);
    `CHK(core_req.req, 1'b0, "request after clear")
    wr_reg(`REG_LVL1, 8'h02);
    pulse_evt(18'h0_0028);
    wait_req();
    `CHK(core_req.vec_idx, 4'h9, "high vector beats low vector")
    `CHK(core_req.level, `LVL_HIGH, "upper level of vector nine")
    rd_reg(`REG_FLAG2, v);
    `CHK(v, 8'h24, "source flags of two vectors")
    clr_flags();
    wr_reg(`REG_LVL1, 8'h00);
    wr_reg(`REG_LVL0, 8'h01);
    ack_en <= 1'b1;
    $display("test priority done");
  endtask : test_prio

  task automatic test_nest();
    pulse_evt(18'h1_0000);
    tick(8);
    pulse_evt(18'h0_0400);
    tick(8);
    rd_reg(`REG_STAT, v);
    `CHK(v, 8'h41, "equal level refused")
    ack_en <= 1'b0;
    pulse_pin(7'h40);
    wait_req();
    `CHK(core_req.level, `LVL_TOP, "highest level shown")
    ack_en <= 1'b1;
    tick(6);
    rd_reg(`REG_STAT, v);
    `CHK(v, 8'h05, "nested in service")
    clr_flags();
    do_ret();
    rd_reg(`REG_STAT, v);
    `CHK(v[2:0], 3'h1, "outer level back")
    do_ret();
    rd_reg(`REG_STAT, v);
    `CHK(v[2:0], 3'h0, "idle again")
    wr_reg(`REG_LVL0, 8'h00);
    $display("test nesting done");
  endtask : test_nest

  task automatic test_stby();
    ack_en <= 1'b0;
    wr_reg(`REG_STBY, 8'h01);
    tick(3);
    `CHK(power, 5'h10, "halt controls")
    rd_reg(`REG_STBY, v);
    `CHK(v, 8'h01, "halt code")
    pulse_evt(18'h1_0000);
    wait_wake(5'h00);
    clr_flags();
    wr_reg(`REG_STBY, 8'h02);
    tick(3);
    `CHK(power, 5'h1F, "hold controls")
    pulse_evt(18'h1_2000);
    tick(8);
    `CHK(power, 5'h1F, "timer must not end hold")
    pulse_pin(7'h40);
    `CHK(power, 5'h1F, "edge pin must not end hold")
    pulse_pin(7'h01);
    wait_wake(5'h00);
    clr_flags();
    wr_reg(`REG_EXTCFG, 8'h01);
    wr_reg(`REG_STBY, 8'h02);
    tick(3);
    pulse_pin(7'h40);
    wait_wake(5'h00);
    clr_flags();
    wr_reg(`REG_EXTCFG, 8'h00);
    xtal_on <= 1'b0;
    wr_reg(`REG_STBY, 8'h03);
    tick(3);
    `CHK(power, 5'h1B, "crystal hold, crystal off")
    pulse_evt(18'h0_0800);
    wait_wake(5'h00);
    clr_flags();
    xtal_on <= 1'b1;
    wr_reg(`REG_STBY, 8'h03);
    tick(3);
    `CHK(power, 5'h1A, "crystal hold, crystal on")
    pulse_evt(18'h0_2000);
    wait_wake(5'h00);
    clr_flags();
    $display("test standby done");
  endtask : test_stby

  task automatic test_rst_wake();
    wr_reg(`REG_STBY, 8'h02);
    tick(3);
    `CHK(power, 5'h1F, "hold before reset")
    reset_n <= 1'b0;
    tick(2);
    `CHK(power, 5'h00, "reset clears controls")
    reset_n <= 1'b1;
    rd_reg(`REG_STBY, v);
    `CHK(v, 8'h00, "reset ends hold")
    $display("test reset wake done");
  endtask : test_rst_wake

  initial begin
    mismatches  = 0;
    comparisons = 0;
    reset_n = 1'b0;
    xtal_on = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    ack_en  = 1'b1;
    ret_cmd = 1'b0;
    addr    = 4'h0;
    delay   = 4'h0;
    wdata   = 8'h00;
    pins    = '0;
    evt     = '0;
    tick(3);
    reset_n <= 1'b1;
    test_reset();
    test_map();
    test_prio();
    test_nest();
    test_stby();
    test_rst_wake();
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
